// file: rlps_seq.sv
// Reset and low-power sequencer: reset pin, watchdog reset, PLL wait, boot select, idle levels.
// Assumes CPU cycle and half-cycle tick pulses and idle, wake and watchdog pulses on mclk_i.

`timescale 1ns/1ns

module rlps_seq
	import rlps_pkg::*;
#(
	parameter logic [CNT_W-1:0] PLL_LOCK_REF = PLL_LOCK_REF_MAX
)
(
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic reset_pin_n_i,
	input wire logic ref_clk_i,
	input wire logic pll_lock_i,
	input wire logic tdi_i,
	input wire logic trst_i,
	input wire logic cpu_tick_i,
	input wire logic cpu_half_i,
	input wire logic wdog_en_i,
	input wire logic wdog_rst_i,
	input wire logic idle_exec_i,
	input wire logic [1:0] lpm_sel_i,
	input wire logic wake_irq_i,
	input wire logic pin_mux_bit7_i,
	input wire logic [PS_W-1:0] clock_prescale_field_i,
	output logic reset_pin_n_o,
	output logic reset_pin_n_oe_o,
	output logic cpu_rst_o,
	output logic cpu_run_o,
	output logic exec_start_o,
	output logic resume_o,
	output logic boot_rom_en_o,
	output logic scan_tdi_o,
	output logic port_b_bit5_o,
	output logic cpu_clock_output_en_o,
	output logic cpu_clk_stop_o,
	output logic osc_pll_pd_o,
	output logic [PS_W-1:0] clock_prescale_field_o
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------

	logic [1:0] pin_m_ff;
	logic [1:0] pin_s_ff;
	logic ref_d_ff;
	logic pin_s;
	logic ref_s;
	logic lock_s;
	logic tdi_s;
	logic trst_s;
	logic ref_edge;

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			pin_m_ff <= 2'h0;
			pin_s_ff <= 2'h0;
			ref_d_ff <= 1'b0;
		end
		else
		begin
			pin_m_ff <= {reset_pin_n_i, ref_clk_i};
			pin_s_ff <= pin_m_ff;
			ref_d_ff <= pin_s_ff[0];
		end
	end

	logic [2:0] aux_m_ff;
	logic [2:0] aux_s_ff;

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			aux_m_ff <= 3'h0;
			aux_s_ff <= 3'h0;
		end
		else
		begin
			aux_m_ff <= {pll_lock_i, tdi_i, trst_i};
			aux_s_ff <= aux_m_ff;
		end
	end

	assign pin_s = pin_s_ff[1];
	assign ref_s = pin_s_ff[0];
	assign lock_s = aux_s_ff[2];
	assign tdi_s = aux_s_ff[1];
	assign trst_s = aux_s_ff[0];
	assign ref_edge = ref_s && !ref_d_ff;

	// ----------------------------------------------------------------
	// Reset pin low-time detector
	// ----------------------------------------------------------------

	logic [3:0] low_cnt_ff;
	logic [3:0] nxt_low_cnt;
	logic rst_seen;

	// Own drive is ignored so the pin the device drives low does not retrigger a reset.
	always_comb
	begin
		nxt_low_cnt = low_cnt_ff;
		if (pin_s || reset_pin_n_oe_o)
			nxt_low_cnt = 4'h0;
		else if (ref_edge && (low_cnt_ff != REF_LOW_MIN))
			nxt_low_cnt = low_cnt_ff + 4'h1;
	end

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			low_cnt_ff <= 4'h0;
		else
			low_cnt_ff <= nxt_low_cnt;
	end

	assign rst_seen = (low_cnt_ff == REF_LOW_MIN);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------

	rlps_state_e state_ff;
	rlps_state_e nxt_state;
	logic [1:0] lpm_ff;
	logic [1:0] nxt_lpm;
	logic por_ff;
	logic nxt_por;
	logic cnt_load;
	logic [CNT_W-1:0] cnt_val;
	logic cnt_tick;
	logic cnt_zero;
	logic wd_req;

	assign wd_req = wdog_en_i && wdog_rst_i;

	rlps_cnt u_cnt
	(
		.mclk_i(mclk_i),
		.nrst_i(nrst_i),
		.load_i(cnt_load),
		.val_i(cnt_val),
		.tick_i(cnt_tick),
		.zero_o(cnt_zero)
	);

	always_comb
	begin
		nxt_state = state_ff;
		nxt_lpm = lpm_ff;
		nxt_por = por_ff;
		cnt_load = 1'b0;
		cnt_val = '0;
		case (state_ff)
			ST_POR_EXT, ST_WD, ST_PLL, ST_WAKE_PLL: cnt_tick = ref_edge;
			ST_EXEC: cnt_tick = cpu_half_i;
			default: cnt_tick = cpu_tick_i;
		endcase
		case (state_ff)
			ST_RESET:
				if (pin_s)
				begin
					cnt_load = 1'b1;
					if (por_ff)
					begin
						nxt_state = ST_POR_EXT;
						cnt_val = POR_EXT_REF;
					end
					else
					begin
						nxt_state = ST_PLL;
						cnt_val = PLL_LOCK_REF;
					end
				end
			ST_POR_EXT, ST_WD:
				if (cnt_zero)
				begin
					nxt_state = ST_PLL;
					nxt_por = 1'b0;
					cnt_load = 1'b1;
					cnt_val = PLL_LOCK_REF;
				end
			ST_PLL:
				if (lock_s || cnt_zero)
				begin
					nxt_state = ST_EXEC;
					cnt_load = 1'b1;
					cnt_val = EXEC_HALF;
				end
			ST_EXEC:
				if (cnt_zero)
					nxt_state = ST_RUN;
			ST_RUN:
				if (wd_req)
				begin
					nxt_state = ST_WD;
					cnt_load = 1'b1;
					cnt_val = WD_PULSE_REF;
				end
				else if (idle_exec_i)
				begin
					nxt_state = ST_ENTRY;
					nxt_lpm = lpm_sel_i;
					cnt_load = 1'b1;
					cnt_val = IDLE_DLY_CYC;
				end
			ST_ENTRY:
				if (cnt_zero)
					nxt_state = ST_IDLE;
			ST_IDLE:
				if (wake_irq_i)
				begin
					cnt_load = 1'b1;
					if (lpm_ff == LPM_DEEP)
					begin
						nxt_state = ST_WAKE_PLL;
						cnt_val = PLL_LOCK_REF;
					end
					else
					begin
						nxt_state = ST_WAKE_DLY;
						cnt_val = (lpm_ff == LPM_LIGHT) ? WAKE_LIGHT_CYC : WAKE_MID_CYC;
					end
				end
			ST_WAKE_PLL:
				if (lock_s || cnt_zero)
				begin
					nxt_state = ST_WAKE_DLY;
					cnt_load = 1'b1;
					cnt_val = WAKE_MID_CYC;
				end
			ST_WAKE_DLY:
				if (cnt_zero)
					nxt_state = ST_RUN;
			default:
				nxt_state = ST_RESET;
		endcase
		// A recognised pin reset overrides every state but ST_RESET and the two the device drives itself.
		if (rst_seen && (state_ff != ST_RESET) && (state_ff != ST_WD) && (state_ff != ST_POR_EXT))
			nxt_state = ST_RESET;
	end

	// ----------------------------------------------------------------
	// Output values
	// ----------------------------------------------------------------

	logic nxt_oe;
	logic nxt_cpu_rst;
	logic nxt_boot_rom;
	logic boot_done_ff;
	logic nxt_boot_done;
	logic [PS_W-1:0] nxt_ps;

	always_comb
	begin
		nxt_oe = (nxt_state == ST_POR_EXT) || (nxt_state == ST_WD);
		nxt_cpu_rst = (nxt_state == ST_RESET) || nxt_oe || (nxt_state == ST_PLL)
			|| (nxt_state == ST_EXEC);
		nxt_boot_rom = boot_rom_en_o;
		nxt_boot_done = boot_done_ff;
		if ((state_ff == ST_PLL) && (nxt_state == ST_EXEC))
		begin
			nxt_boot_rom = tdi_s;
			nxt_boot_done = 1'b1;
		end
		else if ((nxt_state == ST_RESET) || (nxt_state == ST_WD))
			nxt_boot_done = 1'b0;
		nxt_ps = (state_ff == ST_RUN) ? clock_prescale_field_i : clock_prescale_field_o;
	end

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			state_ff <= ST_RESET;
			lpm_ff <= LPM_LIGHT;
			por_ff <= 1'b1;
			reset_pin_n_o <= 1'b0;
			reset_pin_n_oe_o <= 1'b0;
			cpu_rst_o <= 1'b1;
			cpu_run_o <= 1'b0;
			exec_start_o <= 1'b0;
			resume_o <= 1'b0;
			boot_rom_en_o <= 1'b0;
			boot_done_ff <= 1'b0;
			scan_tdi_o <= 1'b0;
			port_b_bit5_o <= 1'b0;
			cpu_clock_output_en_o <= 1'b0;
			cpu_clk_stop_o <= 1'b0;
			osc_pll_pd_o <= 1'b0;
			clock_prescale_field_o <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
			lpm_ff <= nxt_lpm;
			por_ff <= nxt_por;
			reset_pin_n_o <= 1'b0;
			reset_pin_n_oe_o <= nxt_oe;
			cpu_rst_o <= nxt_cpu_rst;
			cpu_run_o <= (nxt_state == ST_RUN);
			exec_start_o <= (state_ff == ST_EXEC) && (nxt_state == ST_RUN);
			resume_o <= (state_ff == ST_WAKE_DLY) && (nxt_state == ST_RUN);
			boot_rom_en_o <= nxt_boot_rom;
			boot_done_ff <= nxt_boot_done;
			scan_tdi_o <= nxt_boot_done && trst_s && tdi_s;
			port_b_bit5_o <= nxt_boot_done && !trst_s && tdi_s;
			cpu_clock_output_en_o <= !nxt_cpu_rst && pin_mux_bit7_i;
			cpu_clk_stop_o <= (nxt_state == ST_IDLE) && (nxt_lpm == LPM_MID);
			osc_pll_pd_o <= (nxt_state == ST_IDLE) && (nxt_lpm == LPM_DEEP);
			clock_prescale_field_o <= nxt_ps;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------

	logic [CNT_W-1:0] seen_ff;

	// Counts counter ticks spent in the current state.
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			seen_ff <= '0;
		else if (state_ff != nxt_state)
			seen_ff <= '0;
		else if (cnt_tick)
			seen_ff <= seen_ff + 1'b1;
	end

	a_wd_pin_drive: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(state_ff == ST_RUN && wd_req && !rst_seen) |=> reset_pin_n_oe_o)
		else $error("watchdog reset did not drive the reset pin");
	a_drive_len_ok: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		((state_ff == ST_WD || state_ff == ST_POR_EXT) && nxt_state == ST_PLL)
		|-> seen_ff == 17'h00080)
		else $error("reset pin drive was not 128 reference cycles");
	a_clk_pin_off: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		cpu_rst_o |-> !cpu_clock_output_en_o)
		else $error("clock routed to pin during reset");
	a_exec_delay_ok: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(state_ff == ST_EXEC && nxt_state == ST_RUN) |-> seen_ff == 17'h00024 ##1 exec_start_o)
		else $error("reset vector not run after 36 half-periods");
	a_lock_ends_wait: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(state_ff == ST_PLL && lock_s && !rst_seen) |=> state_ff == ST_EXEC)
		else $error("PLL lock did not end the wait");
	a_mid_clk_stop: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(state_ff == ST_ENTRY && nxt_state == ST_IDLE && lpm_ff == LPM_MID)
		|-> seen_ff == 17'h00004 ##1 cpu_clk_stop_o)
		else $error("middle level clock stop not 4 cycles after idle");
	a_deep_pd_time: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(state_ff == ST_ENTRY && nxt_state == ST_IDLE && lpm_ff == LPM_DEEP)
		|-> seen_ff == 17'h00004 ##1 osc_pll_pd_o)
		else $error("deep level power-down not 4 cycles after idle");
	a_wake_resume: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(state_ff == ST_WAKE_DLY && nxt_state == ST_RUN)
		|-> seen_ff == ((lpm_ff == LPM_LIGHT) ? 17'h0000C : 17'h0000F))
		else $error("wake-up resume delay wrong");
	a_lpm_held: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(state_ff == ST_IDLE) |=> $stable(lpm_ff))
		else $error("idle level changed before wake-up");
	a_ps_restore: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(state_ff != ST_RUN) |=> $stable(clock_prescale_field_o))
		else $error("prescale changed outside run");
	a_boot_sample: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(state_ff == ST_PLL && nxt_state == ST_EXEC) |=> boot_rom_en_o == $past(tdi_s))
		else $error("boot select not sampled from scan data pin");

endmodule

// file: rlps_timer.sv
// Shared constants and the down-counter used by the reset and low-power sequencer.
// Assumes one clock, mclk_i at 125 MHz, and an active-low asynchronous reset nrst_i.
//
// Contract
// - Allow the PLL up to 98304 reference cycles to lock after reset.
// - Execute reset vector 36 CPU half-periods after the lock interval.
// - On power-on, keep driving the reset pin low 128 more reference cycles.
// - Enabled watchdog reset drives the reset pin low 128 reference cycles.
// - CPU clock reaches its pin only after reset and mux bit 7 set.
// - Sample the scan data pin during boot select to enable the boot loader.
// - Afterwards the pin is scan data with TRST high, port B bit 5 otherwise.
// - Resume 12 CPU cycles after wake from light, 15 from middle level.
// - Middle level stops the CPU clock high 4 cycles after idle entry.
// - Deep level powers down oscillator and PLL 4 cycles after idle entry.
// - Deep wake restarts oscillator and waits for PLL lock before resuming.
// - Reset ending an idle state runs the vector 36 half-periods later.
// - Any enabled interrupt or a reset wakes the light and middle levels.
// - Deep wake restores the CPU clock prescale that was in effect at entry.

package rlps_pkg;

	localparam int CNT_W = 17;
	localparam logic [3:0] REF_LOW_MIN = 4'h8;
	localparam logic [CNT_W-1:0] POR_EXT_REF = 17'h00080;
	localparam logic [CNT_W-1:0] WD_PULSE_REF = 17'h00080;
	localparam logic [CNT_W-1:0] PLL_LOCK_REF_MAX = 17'h18000;
	localparam logic [CNT_W-1:0] EXEC_HALF = 17'h00024;
	localparam logic [CNT_W-1:0] IDLE_DLY_CYC = 17'h00004;
	localparam logic [CNT_W-1:0] WAKE_LIGHT_CYC = 17'h0000C;
	localparam logic [CNT_W-1:0] WAKE_MID_CYC = 17'h0000F;
	localparam int PS_W = 3;

	typedef enum logic [1:0]
	{
		LPM_LIGHT = 2'h0,
		LPM_MID = 2'h1,
		LPM_DEEP = 2'h2
	} rlps_lpm_e;

	typedef enum logic [3:0]
	{
		ST_RESET = 4'h0,
		ST_POR_EXT = 4'h1,
		ST_WD = 4'h2,
		ST_PLL = 4'h3,
		ST_EXEC = 4'h4,
		ST_RUN = 4'h5,
		ST_ENTRY = 4'h6,
		ST_IDLE = 4'h7,
		ST_WAKE_PLL = 4'h8,
		ST_WAKE_DLY = 4'h9
	} rlps_state_e;

endpackage

`timescale 1ns/1ns

module rlps_cnt
	import rlps_pkg::*;
(
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic load_i,
	input wire logic [CNT_W-1:0] val_i,
	input wire logic tick_i,
	output logic zero_o
);

	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;

	// Load wins over a tick in the same cycle.
	always_comb
	begin
		nxt_cnt = cnt_ff;
		if (load_i)
			nxt_cnt = val_i;
		else if (tick_i && (cnt_ff != '0))
			nxt_cnt = cnt_ff - 1'b1;
	end

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			cnt_ff <= '0;
		else
			cnt_ff <= nxt_cnt;
	end

	assign zero_o = (cnt_ff == '0);

endmodule

// file: rlps_far_end.sv
// Far-side model: reset source with pull-up, free-running reference clock, PLL lock, emulator.
// Assumes the bench orders pin pulls and scan reset requests.
`timescale 1ns/1ns
module rlps_far_end
#(
	parameter int REF_HALF_NS = 20,
	parameter int LOCK_NS = 400
)
(
	input wire logic pull_low_i,
	input wire logic dev_drive_i,
	input wire logic dev_level_i,
	input wire logic pd_i,
	input wire logic trst_req_i,
	output logic pin_o,
	output logic ref_clk_o,
	output logic lock_o,
	output logic trst_o
);
	initial ref_clk_o = 1'b0;
	always #(REF_HALF_NS) ref_clk_o = ~ref_clk_o;
	// ----------------------------------------
	// Pin and lock
	// ----------------------------------------
	// The pin is pulled up unless either party drives it low.
	assign pin_o = !(pull_low_i || (dev_drive_i && !dev_level_i));
	always
	begin
		lock_o = 1'b0;
		wait (pd_i === 1'b0);
		#(LOCK_NS);
		if (pd_i === 1'b0)
			lock_o = 1'b1;
		wait (pd_i === 1'b1);
	end
	// Scan reset stays low while the device is held in reset.
	assign trst_o = trst_req_i && pin_o;
endmodule

// file: tb_top.sv
// Self-checking bench for the reset and low-power sequencer.
// Assumes rlps_pkg, rlps_seq and rlps_far_end are compiled first.
`timescale 1ns/1ns
module tb_top;
	import rlps_pkg::*;
	logic mclk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic pull = 1'b1;
	logic trq = 1'b0;
	logic tdi = 1'b1;
	logic wen = 1'b0;
	logic wrst = 1'b0;
	logic idle = 1'b0;
	logic [1:0] lpm = 2'h0;
	logic wake = 1'b0;
	logic mux7 = 1'b1;
	logic [PS_W-1:0] ps = 3'h2;
	logic [1:0] ph = 2'h0;
	logic tick = 1'b0;
	logic half = 1'b0;
	wire pin, rclk, lock, trst, pin_o, oe, rst, run, ex, res, boot, scan, pb5, coe, stop, pd;
	wire [PS_W-1:0] ps_o;
	wire [6:0] mon = {run, pd, stop, res, ex, rst, oe};
	int failures = 0;
	int checked = 0;
	int nc, nt, nh;
	always #4 mclk_i = ~mclk_i;
	always @(negedge mclk_i)
	begin
		ph <= ph + 2'h1;
		tick <= (ph == 2'h3);
		half <= ph[0];
	end
	rlps_far_end rlps_far_end_inst (.pull_low_i(pull), .dev_drive_i(oe), .dev_level_i(pin_o),
		.pd_i(pd), .trst_req_i(trq), .pin_o(pin), .ref_clk_o(rclk), .lock_o(lock), .trst_o(trst));
	rlps_seq #(.PLL_LOCK_REF(17'h00040)) rlps_seq_inst (.mclk_i(mclk_i), .nrst_i(nrst_i),
		.reset_pin_n_i(pin), .ref_clk_i(rclk), .pll_lock_i(lock), .tdi_i(tdi), .trst_i(trst),
		.cpu_tick_i(tick), .cpu_half_i(half), .wdog_en_i(wen), .wdog_rst_i(wrst),
		.idle_exec_i(idle), .lpm_sel_i(lpm), .wake_irq_i(wake), .pin_mux_bit7_i(mux7),
		.clock_prescale_field_i(ps), .reset_pin_n_o(pin_o), .reset_pin_n_oe_o(oe), .cpu_rst_o(rst),
		.cpu_run_o(run), .exec_start_o(ex), .resume_o(res), .boot_rom_en_o(boot),
		.scan_tdi_o(scan), .port_b_bit5_o(pb5), .cpu_clock_output_en_o(coe),
		.cpu_clk_stop_o(stop), .osc_pll_pd_o(pd), .clock_prescale_field_o(ps_o));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task check(input string nm, input logic [16:0] seen, input logic [16:0] exp);
		checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("FAIL %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	// Waits for one output level, counting cycles, CPU ticks and half ticks on the way.
	task wait_bit(input string nm, input int i, input logic v, input int lim);
		nc = 0;
		nt = 0;
		nh = 0;
		while (mon[i] !== v && nc < lim)
		begin
			@(posedge mclk_i);
			nt += tick;
			nh += half;
			nc++;
			#1;
		end
		check(nm, mon[i], v);
		@(negedge mclk_i);
	endtask
	// Leaves at the falling edge just after a tick, so no tick meets a count load.
	task align;
		do @(posedge mclk_i); while (tick !== 1'b1);
		@(negedge mclk_i);
	endtask
	task test_done;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_por;
		cyc(60);
		check("coe_rst", coe, 1'b0);
		pull = 1'b0;
		wait_bit("por_drive", 0, 1'b1, 20);
		wait_bit("por_end", 0, 1'b0, 700);
		check("por_len", nc >= 630 && nc <= 650, 1'b1);
		wait_bit("vector", 2, 1'b1, 200);
		check("halves", nh >= 36 && nh <= 39, 1'b1);
		check("boot", boot, 1'b1);
		check("core_rst", rst, 1'b0);
		cyc(2);
		check("coe_on", coe, 1'b1);
		trq = 1'b1;
		cyc(4);
		check("scan", {scan, pb5}, 2'h2);
		trq = 1'b0;
		cyc(4);
		check("gpio", {scan, pb5}, 2'h1);
		mux7 = 1'b0;
		cyc(2);
		check("coe_off", coe, 1'b0);
		$display("test por done");
	endtask
	task t_idle(input logic [1:0] lv, input int lo, input int hi);
		align();
		lpm = lv;
		idle = 1'b1;
		cyc(1);
		idle = 1'b0;
		check("run_off", run, 1'b0);
		if (lv != 2'h0)
		begin
			wait_bit("halt", 3 + lv, 1'b1, 40);
			check("entry_ticks", nt, 17'h4);
		end
		lpm = 2'h0;
		ps = 3'h5;
		cyc(24);
		check("stop", stop, lv == 2'h1);
		check("pd", pd, lv == 2'h2);
		check("ps_hold", ps_o, 3'h2);
		align();
		wake = 1'b1;
		cyc(1);
		wake = 1'b0;
		wait_bit("resume", 3, 1'b1, 300);
		check("ps_wake", ps_o, 3'h2);
		check("wake_ticks", nt >= lo && nt <= hi, 1'b1);
		check("run_on", {run, stop, pd}, 3'h4);
		ps = 3'h2;
		$display("test idle %0d done", lv);
	endtask
	task t_wdog;
		wrst = 1'b1;
		cyc(1);
		wrst = 1'b0;
		cyc(3);
		check("wd_off", {oe, rst}, 2'h0);
		wen = 1'b1;
		wrst = 1'b1;
		cyc(1);
		wrst = 1'b0;
		wait_bit("wd_drive", 0, 1'b1, 3);
		check("wd_rst", rst, 1'b1);
		check("wd_level", pin_o, 1'b0);
		wait_bit("wd_end", 0, 1'b0, 700);
		check("wd_len", nc >= 630 && nc <= 650, 1'b1);
		wait_bit("wd_vector", 2, 1'b1, 200);
		wen = 1'b0;
		$display("test watchdog done");
	endtask
	task t_warm;
		tdi = 1'b0;
		lpm = 2'h0;
		idle = 1'b1;
		cyc(1);
		idle = 1'b0;
		cyc(24);
		pull = 1'b1;
		cyc(60);
		check("warm_rst", {rst, oe}, 2'h2);
		pull = 1'b0;
		wait_bit("warm_vector", 2, 1'b1, 200);
		check("warm_halves", nh >= 36 && nh <= 40, 1'b1);
		check("warm_boot", boot, 1'b0);
		$display("test warm done");
	endtask
	initial
	begin
		cyc(10);
		nrst_i = 1'b1;
		t_por();
		t_idle(2'h0, 12, 12);
		t_idle(2'h1, 15, 15);
		t_idle(2'h2, 27, 31);
		t_wdog();
		t_warm();
		test_done();
	end
	initial
	begin
		#100000;
		failures++;
		test_done();
	end
endmodule
